// *** hdl/sfpm_pkg.sv ***
// Constants, types and behaviour notes for the serial flash power mode control
// Notes on behaviour
// - Whenever chip select is low and the part is not asleep, it is enabled and in active power mode (the code ignores select low in both settling delays).
// - After chip select rises the part stays active until pending program, erase and write work ends, then drops to standby.
// - Deep sleep is requested by the host sending the enter-sleep code B9h in a frame that started from standby.
// - The enter-sleep code is taken only while the write_in_progress flag reads zero.
// - Deep sleep begins only after chip select rises behind the enter-sleep code and the sleep_entry_delay has run out.
// - In deep sleep every instruction is ignored except the wake_command code ABh, which is recognised.
// - In deep sleep a frame with no clocking, or with any code other than the wake_command, leaves the part asleep.
// - After the wake_command the part returns to standby once chip select rises and the wake_delay has run out.
package sfpm_pkg;

   // ----------------------------------------------------------------
   // Instruction codes
   // ----------------------------------------------------------------
   localparam logic [7:0] SFPM_CODE_SLEEP = 8'hB9;
   localparam logic [7:0] SFPM_CODE_WAKE  = 8'hAB;
   localparam logic [2:0] SFPM_LAST_BIT   = 3'h7;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int SFPM_CLK_MHZ        = 125;
   localparam int SFPM_SLEEP_ENTRY_NS = 3000;
   localparam int SFPM_WAKE_NS        = 3000;
   localparam int SFPM_CNT_W          = 16;
   localparam int SFPM_SYNC_W         = 3;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SFPM_ST_STANDBY,
      SFPM_ST_ACTIVE,
      SFPM_ST_SLEEP_DELAY,
      SFPM_ST_DEEP,
      SFPM_ST_WAKE_DELAY
   } sfpm_state_e;

   typedef struct packed {
      logic active;
      logic standby;
      logic deep_sleep;
      logic settling;
   } sfpm_status_s;

   typedef struct packed {
      logic       valid;
      logic [7:0] code;
   } sfpm_cmd_s;

   localparam sfpm_status_s SFPM_STATUS_RST = '{active: 1'b0, standby: 1'b1, deep_sleep: 1'b0, settling: 1'b0};

endpackage : sfpm_pkg

// *** hdl/sfpm_sync.sv ***
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module sfpm_sync
   import sfpm_pkg::*;
#(
   parameter int         W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] async_i,
   output logic [W-1:0]      sync_o
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule : sfpm_sync
`default_nettype wire

// *** hdl/sfpm_ctrl.sv ***
// Power mode tracker for a serial flash: active, standby and deep sleep
`timescale 1ns/1ps
`default_nettype none
module sfpm_ctrl
   import sfpm_pkg::*;
#(
   parameter int SLEEP_ENTRY_NS = SFPM_SLEEP_ENTRY_NS,
   parameter int WAKE_NS        = SFPM_WAKE_NS
) (
   input  wire logic   clk,
   input  wire logic   arst_n,
   input  wire logic   select_low_n,
   input  wire logic   sck,
   input  wire logic   si,
   input  wire logic   write_in_progress,
   input  wire logic   ops_pending,
   output sfpm_status_s status,
   output sfpm_cmd_s    cmd,
   output logic         seq_error
);

   // ----------------------------------------------------------------
   // Delay counts, least times rounded up
   // ----------------------------------------------------------------
   localparam int SLEEP_CYC_I = (SLEEP_ENTRY_NS * SFPM_CLK_MHZ + 999) / 1000;
   localparam int WAKE_CYC_I  = (WAKE_NS * SFPM_CLK_MHZ + 999) / 1000;
   localparam logic [SFPM_CNT_W-1:0] SLEEP_LAST = SFPM_CNT_W'((SLEEP_CYC_I < 1 ? 1 : SLEEP_CYC_I) - 1);
   localparam logic [SFPM_CNT_W-1:0] WAKE_LAST  = SFPM_CNT_W'((WAKE_CYC_I < 1 ? 1 : WAKE_CYC_I) - 1);
   localparam logic [SFPM_CNT_W-1:0] CNT_ONE    = SFPM_CNT_W'(1);

   // ----------------------------------------------------------------
   // Pin synchronisation and edges
   // ----------------------------------------------------------------
   logic [SFPM_SYNC_W-1:0] pins_s;
   logic                   cs_s;
   logic                   sck_s;
   logic                   si_s;
   logic                   cs_prev_q;
   logic                   sck_prev_q;

   sfpm_sync #(
      .W       (SFPM_SYNC_W),
      .RST_VAL (3'h4)
   ) u_sync (
      .clk     (clk),
      .arst_n  (arst_n),
      .async_i ({select_low_n, sck, si}),
      .sync_o  (pins_s)
   );

   assign cs_s  = pins_s[2];
   assign sck_s = pins_s[1];
   assign si_s  = pins_s[0];

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cs_prev_q  <= 1'b1;
         sck_prev_q <= 1'b0;
      end else begin
         cs_prev_q  <= cs_s;
         sck_prev_q <= sck_s;
      end
   end

   wire cs_fall  = cs_prev_q & ~cs_s;
   wire cs_rise  = ~cs_prev_q & cs_s;
   wire sck_rise = ~sck_prev_q & sck_s & ~cs_s;

   // ----------------------------------------------------------------
   // First byte of each frame
   // ----------------------------------------------------------------
   logic [6:0] shift_q;
   logic [2:0] bit_q;
   logic       byte_seen_q;

   wire        byte_done = sck_rise & (bit_q == SFPM_LAST_BIT) & ~byte_seen_q;
   wire [7:0]  code_in   = {shift_q, si_s};

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         shift_q     <= '0;
         bit_q       <= '0;
         byte_seen_q <= 1'b0;
      end else if (cs_fall) begin
         bit_q       <= '0;
         byte_seen_q <= 1'b0;
      end else if (sck_rise && !byte_seen_q) begin
         shift_q     <= code_in[6:0];
         bit_q       <= bit_q + 3'h1;
         byte_seen_q <= byte_done;
      end
   end

   // ----------------------------------------------------------------
   // Power mode sequencer
   // ----------------------------------------------------------------
   sfpm_state_e            state_q;
   sfpm_state_e            state_d;
   logic [SFPM_CNT_W-1:0]  cnt_q;
   logic [SFPM_CNT_W-1:0]  cnt_d;
   logic                   from_standby_q;
   logic                   from_standby_d;
   logic                   sleep_armed_q;
   logic                   sleep_armed_d;
   logic                   wake_armed_q;
   logic                   wake_armed_d;
   logic                   seq_error_q;

   wire in_deep      = (state_q == SFPM_ST_DEEP);
   wire in_active    = (state_q == SFPM_ST_ACTIVE);
   wire sleep_req    = byte_done & (code_in == SFPM_CODE_SLEEP);
   wire wake_req     = byte_done & (code_in == SFPM_CODE_WAKE);
   wire sleep_accept = in_active & from_standby_q & sleep_req & ~write_in_progress;

   always_comb begin
      state_d        = state_q;
      cnt_d          = '0;
      from_standby_d = from_standby_q;
      sleep_armed_d  = sleep_armed_q;
      wake_armed_d   = wake_armed_q;
      case (state_q)
         SFPM_ST_STANDBY: begin
            if (!cs_s) begin
               state_d        = SFPM_ST_ACTIVE;
               from_standby_d = 1'b1;
            end
         end
         SFPM_ST_ACTIVE: begin
            if (sleep_accept) begin
               sleep_armed_d = 1'b1;
            end
            if (cs_fall) begin
               sleep_armed_d  = 1'b0;
               from_standby_d = 1'b0;
            end
            if (cs_s && sleep_armed_q) begin
               state_d        = SFPM_ST_SLEEP_DELAY;
               sleep_armed_d  = 1'b0;
               from_standby_d = 1'b0;
            end else if (cs_s && !ops_pending) begin
               state_d        = SFPM_ST_STANDBY;
               from_standby_d = 1'b0;
            end
         end
         SFPM_ST_SLEEP_DELAY: begin
            cnt_d = cnt_q + CNT_ONE;
            if (cnt_q == SLEEP_LAST) begin
               state_d = SFPM_ST_DEEP;
               cnt_d   = '0;
            end
         end
         SFPM_ST_DEEP: begin
            if (cs_fall) begin
               wake_armed_d = 1'b0;
            end else if (wake_req) begin
               wake_armed_d = 1'b1;
            end
            if (cs_rise && wake_armed_q) begin
               state_d      = SFPM_ST_WAKE_DELAY;
               wake_armed_d = 1'b0;
            end
         end
         SFPM_ST_WAKE_DELAY: begin
            cnt_d = cnt_q + CNT_ONE;
            if (cnt_q == WAKE_LAST) begin
               state_d = SFPM_ST_STANDBY;
               cnt_d   = '0;
            end
         end
         default: begin
            state_d = SFPM_ST_STANDBY;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q        <= SFPM_ST_STANDBY;
         cnt_q          <= '0;
         from_standby_q <= 1'b0;
         sleep_armed_q  <= 1'b0;
         wake_armed_q   <= 1'b0;
      end else begin
         state_q        <= state_d;
         cnt_q          <= cnt_d;
         from_standby_q <= from_standby_d;
         sleep_armed_q  <= sleep_armed_d;
         wake_armed_q   <= wake_armed_d;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         seq_error_q <= 1'b0;
      end else if (state_q == SFPM_ST_WAKE_DELAY && cs_fall) begin
         seq_error_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------
   sfpm_status_s status_q;
   sfpm_cmd_s    cmd_q;

   wire sfpm_status_s status_d = '{
      active:     (state_d == SFPM_ST_ACTIVE),
      standby:    (state_d == SFPM_ST_STANDBY),
      deep_sleep: (state_d == SFPM_ST_DEEP),
      settling:   (state_d == SFPM_ST_SLEEP_DELAY) || (state_d == SFPM_ST_WAKE_DELAY)
   };

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         status_q <= SFPM_STATUS_RST;
         cmd_q    <= '0;
      end else begin
         status_q <= status_d;
         cmd_q.valid <= byte_done & in_active;
         if (byte_done && in_active) begin
            cmd_q.code <= code_in;
         end
      end
   end

   assign status    = status_q;
   assign cmd       = cmd_q;
   assign seq_error = seq_error_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_wake_armed_rise;
      in_deep && cs_rise && wake_armed_q;
   endsequence

   sequence s_sleep_done;
      state_q == SFPM_ST_SLEEP_DELAY && state_d == SFPM_ST_DEEP;
   endsequence

   sequence s_wake_done;
      state_q == SFPM_ST_WAKE_DELAY && state_d == SFPM_ST_STANDBY;
   endsequence

   AST_SELECT_ACTIVE: assert property (@(posedge clk) disable iff (!arst_n)
      (state_q == SFPM_ST_STANDBY && !cs_s) |=> (state_q == SFPM_ST_ACTIVE) && status.active)
      else $error("select low did not make the part active");

   AST_BUSY_HOLDS: assert property (@(posedge clk) disable iff (!arst_n)
      (in_active && ops_pending) |=> (state_q != SFPM_ST_STANDBY))
      else $error("standby entered with operations pending");

   AST_IDLE_STANDBY: assert property (@(posedge clk) disable iff (!arst_n)
      (in_active && cs_s && !ops_pending && !sleep_armed_q) |=> (state_q == SFPM_ST_STANDBY))
      else $error("idle deselected part did not drop to standby");

   AST_SLEEP_NEEDS_IDLE: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(sleep_armed_q) |-> ($past(write_in_progress) == 1'b0) && $past(from_standby_q))
      else $error("enter-sleep taken while busy or not from standby");

   AST_SLEEP_DELAY: assert property (@(posedge clk) disable iff (!arst_n)
      s_sleep_done |-> (cnt_q == SLEEP_LAST) ##1 in_deep ##1 status.deep_sleep)
      else $error("deep sleep entered with wrong delay");

   AST_SLEEP_AFTER_DESELECT: assert property (@(posedge clk) disable iff (!arst_n)
      (state_q == SFPM_ST_SLEEP_DELAY && $past(in_active)) |-> $past(sleep_armed_q) && $past(cs_s))
      else $error("sleep wait began without an armed request");

   AST_DEEP_IGNORES: assert property (@(posedge clk) disable iff (!arst_n)
      in_deep |=> !cmd.valid)
      else $error("instruction forwarded during deep sleep");

   AST_DEEP_STAYS: assert property (@(posedge clk) disable iff (!arst_n)
      (in_deep && !wake_armed_q) |=> in_deep)
      else $error("deep sleep left without the wake code");

   AST_WAKE_START: assert property (@(posedge clk) disable iff (!arst_n)
      s_wake_armed_rise |=> (state_q == SFPM_ST_WAKE_DELAY) [*2])
      else $error("wake wait did not start after deselect");

   AST_WAKE_DELAY: assert property (@(posedge clk) disable iff (!arst_n)
      s_wake_done |-> (cnt_q == WAKE_LAST) ##1 (state_q == SFPM_ST_STANDBY))
      else $error("standby reached with wrong wake delay");

endmodule : sfpm_ctrl
`default_nettype wire

// *** tb/sfpm_host_model.sv ***
// Host controller model driving chip select, serial clock and data
`timescale 1ns/1ps
`default_nettype none
module sfpm_host_model
   import sfpm_pkg::*;
(
   input  wire logic clk,
   output logic      select_low_n,
   output logic      sck,
   output logic      si
);
   initial begin
      select_low_n = 1'b1;
      sck          = 1'b0;
      si           = 1'b0;
   end

   // Half a serial clock period, 32 ns
   task automatic half();
      repeat (4) @(negedge clk);
   endtask : half

   task automatic cs_low();
      @(negedge clk);
      select_low_n = 1'b0;
      half();
   endtask : cs_low

   // code MSB first, clock idles low
   task automatic shift(input logic [7:0] code, input int nbits);
      for (int i = 0; i < nbits; i++) begin
         si = code[7-i];
         half();
         sck = 1'b1;
         half();
         sck = 1'b0;
      end
      half();
   endtask : shift

   task automatic cs_high();
      select_low_n = 1'b1;
      // Released line shows no stale bit
      si = ~si;
      half();
   endtask : cs_high
endmodule : sfpm_host_model
`default_nettype wire

// *** tb/serial_flash_power_mode_control_tb.sv ***
// Self-checking bench for the power mode tracker
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module serial_flash_power_mode_control_tb
   import sfpm_pkg::*;
;
   localparam sfpm_status_s ST_ACT  = 4'h8;
   localparam sfpm_status_s ST_STBY = 4'h4;
   localparam sfpm_status_s ST_DEEP = 4'h2;
   logic         clk;
   logic         arst_n;
   logic         select_low_n;
   logic         sck;
   logic         si;
   logic         write_in_progress;
   logic         ops_pending;
   sfpm_status_s status;
   sfpm_cmd_s    cmd;
   logic         seq_error;
   int           n_mismatch;
   int           n_checks;
   int           n_valid;
   int           cyc;
   logic [7:0]   last_code;

   sfpm_host_model i_host (.clk(clk), .select_low_n(select_low_n), .sck(sck), .si(si));

   sfpm_ctrl #(.SLEEP_ENTRY_NS(40), .WAKE_NS(80)) i_dut (
      .clk(clk), .arst_n(arst_n), .select_low_n(select_low_n), .sck(sck), .si(si),
      .write_in_progress(write_in_progress), .ops_pending(ops_pending),
      .status(status), .cmd(cmd), .seq_error(seq_error));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(negedge clk) begin
      cyc++;
      if (cmd.valid === 1'b1) begin
         n_valid++;
         last_code = cmd.code;
      end
      if (cyc == 10000) begin
         n_mismatch++;
         results();
      end
   end

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : results

   task automatic wait_st(input sfpm_status_s exp, input string nm);
      for (int i = 0; i < 30; i++) begin
         @(negedge clk);
         if (status === exp) break;
      end
      `CHK(nm, exp, status)
   endtask : wait_st

   task automatic frame(input logic [7:0] code, input int nbits);
      i_host.cs_low();
      i_host.shift(code, nbits);
      i_host.cs_high();
   endtask : frame

   task automatic count_settle(input int exp, input sfpm_status_s fin);
      int n;
      n = 0;
      repeat (40) begin
         @(negedge clk);
         if (status.settling === 1'b1) n++;
      end
      `CHK("settle_cycles", exp, n)
      `CHK("after_settle", fin, status)
   endtask : count_settle

   // Deselect and count settling from the same edge
   task automatic release_settle(input int exp, input sfpm_status_s fin);
      fork
         i_host.cs_high();
         count_settle(exp, fin);
      join
   endtask : release_settle

   task automatic t_normal();
      int v0;
      v0 = n_valid;
      ops_pending = 1'b1;
      i_host.cs_low();
      wait_st(ST_ACT, "active_on_select");
      i_host.shift(8'h5A, 8);
      `CHK("valid_pulses", v0 + 1, n_valid)
      `CHK("fwd_code", 8'h5A, last_code)
      i_host.cs_high();
      repeat (20) @(negedge clk);
      `CHK("held_active", ST_ACT, status)
      ops_pending = 1'b0;
      wait_st(ST_STBY, "standby_after_ops");
      $display("test normal done");
   endtask : t_normal

   task automatic t_wip_refuse();
      write_in_progress = 1'b1;
      frame(8'hB9, 8);
      write_in_progress = 1'b0;
      repeat (30) @(negedge clk);
      `CHK("sleep_refused", ST_STBY, status)
      $display("test wip done");
   endtask : t_wip_refuse

   task automatic t_sleep();
      i_host.cs_low();
      i_host.shift(8'hB9, 8);
      repeat (10) @(negedge clk);
      `CHK("awake_while_selected", ST_ACT, status)
      release_settle(5, ST_DEEP);
      $display("test sleep done");
   endtask : t_sleep

   task automatic t_ignore();
      int v0;
      v0 = n_valid;
      frame(8'h00, 0);
      repeat (10) @(negedge clk);
      `CHK("no_clock_frame", ST_DEEP, status)
      frame(8'h9F, 8);
      repeat (10) @(negedge clk);
      `CHK("other_code", ST_DEEP, status)
      frame(8'hAB, 7);
      repeat (10) @(negedge clk);
      `CHK("short_wake", ST_DEEP, status)
      `CHK("nothing_forwarded", v0, n_valid)
      $display("test ignore done");
   endtask : t_ignore

   task automatic t_wake();
      i_host.cs_low();
      i_host.shift(8'hAB, 8);
      release_settle(10, ST_STBY);
      `CHK("no_seq_error", 1'b0, seq_error)
      $display("test wake done");
   endtask : t_wake

   task automatic t_bad_wake();
      i_host.cs_low();
      i_host.shift(8'hB9, 8);
      release_settle(5, ST_DEEP);
      i_host.cs_low();
      i_host.shift(8'hAB, 8);
      i_host.select_low_n = 1'b1;
      wait_st(4'h1, "wake_settling");
      @(negedge clk);
      i_host.select_low_n = 1'b0;
      repeat (4) @(negedge clk);
      i_host.select_low_n = 1'b1;
      wait_st(ST_STBY, "wake_completes");
      `CHK("seq_error_set", 1'b1, seq_error)
      $display("test bad wake done");
   endtask : t_bad_wake

   initial begin
      arst_n            = 1'b0;
      write_in_progress = 1'b0;
      ops_pending       = 1'b0;
      repeat (12) @(negedge clk);
      `CHK("rst_status", SFPM_STATUS_RST, status)
      `CHK("rst_cmd", 9'h000, cmd)
      `CHK("rst_err", 1'b0, seq_error)
      arst_n = 1'b1;
      repeat (4) @(negedge clk);
      t_normal();
      t_wip_refuse();
      t_sleep();
      t_ignore();
      t_wake();
      t_bad_wake();
      results();
   end
endmodule : serial_flash_power_mode_control_tb
`default_nettype wire
